// ---- core/sfl_top.sv ----
// serial frame and loop control: apb registers, tx buffer, tx and rx
// assumes one 100 mhz clock, async active-high reset, apb master outside
//
// Overview of operation
// - loop select cuts off the receive pin and feeds tx output or the tx pin to rx.
// - in loop mode receiver source 0 takes tx output, 1 the tx pin.
// - halt in wait set stops the serial logic while in wait mode.
// - character length bit picks eight or nine data bits per frame.
// - wakeup bit picks idle line or an address mark in the msb.
// - idle count start picks counting after start or after stop bit.
// - parity on puts a parity bit in the character msb, off none.
// - parity odd select picks even or odd parity for tx and rx.
// - the control register is mapped only while alt map select is 0.
`timescale 1ns/1ps
`include "sfl_defs.svh"

// ----------------------------------------------------------------------
// transmit buffer
// ----------------------------------------------------------------------
module sfl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic in_valid, // push request
  output logic in_ready, // space left
  input wire logic [WIDTH-1:0] in_data, // push word
  output logic out_valid, // word present
  input wire logic out_ready, // pop request
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr, count;
  assign count = wr_ptr - rd_ptr;
  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_comb begin
    next_wr_ptr = wr_ptr + (AW+1)'(in_valid && in_ready);
    next_rd_ptr = rd_ptr + (AW+1)'(out_valid && out_ready);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : sfl_fifo

// ----------------------------------------------------------------------
// top level
// ----------------------------------------------------------------------
module sfl_top
  import sfl_pkg::*;
(
  input wire logic clk, // 100 mhz clock
  input wire logic rst, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic wait_mode, // system wait mode, same clock
  input wire logic rxd, // receive pin
  input wire logic txd_in, // transmit pin level
  output logic txd_out, // transmit pin drive value
  output logic txd_oe_n // transmit pin enable, low drives
);
  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic [15:0] baud_div, next_baud_div;
  logic [7:0] ctrl1, next_ctrl1;
  logic [3:0] enab, next_enab;
  logic [8:0] rx_data, next_rx_data;
  logic rx_full, ovr, perr, ferr, idle_f;
  logic next_rx_full, next_ovr, next_perr, next_ferr, next_idle_f;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_txd_oe_n;
  logic rxd_s1, rxd_s2, txi_s1, txi_s2;
  sfl_tx_state_t tx_st, next_tx_st;
  logic [15:0] tx_tmr, next_tx_tmr;
  logic [10:0] tx_sh, next_tx_sh, tx_frame;
  logic [3:0] tx_left, next_tx_left;
  logic tx_line, next_tx_line;
  sfl_rx_state_t rx_st, next_rx_st;
  logic [15:0] rx_tmr, next_rx_tmr;
  logic [8:0] rx_sh, next_rx_sh, rx_char;
  logic [3:0] rx_cnt, next_rx_cnt, ones, next_ones;
  logic armed, next_armed;
  // --------------------------------------------------------------------
  // decode and derived controls
  // --------------------------------------------------------------------
  logic [2:0] idx;
  logic aligned, hit_baud, hit_enab, hit_ctrl, hit_data, hit_stat;
  logic mapped, acc, wr, rd, halted, tx_on, rx_on, nine, div_ok;
  logic [15:0] div;
  logic [3:0] nbits, flen;
  logic f_valid, f_ready, f_pop, rx_in, load, done, idle_ev, keep;
  logic [8:0] f_data, tx_char;
  assign idx = paddr[4:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0);
  assign hit_baud = aligned && idx == `SFL_IDX_BAUD;
  assign hit_enab = aligned && idx == `SFL_IDX_ENAB;
  assign hit_ctrl = aligned && idx == `SFL_IDX_CTRL1
                    && !enab[`SFL_E_ALTMAP];
  assign hit_data = aligned && idx == `SFL_IDX_DATA;
  assign hit_stat = aligned && idx == `SFL_IDX_STAT;
  assign mapped = hit_baud || hit_enab || hit_ctrl || hit_data || hit_stat;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign halted = wait_mode && ctrl1[`SFL_B_HALT];
  assign tx_on = enab[`SFL_E_TX] && !halted;
  assign rx_on = enab[`SFL_E_RX] && !halted;
  assign nine = ctrl1[`SFL_B_NINE];
  assign nbits = nine ? 4'd9 : 4'd8;
  assign flen = nbits + 4'd2;
  assign div_ok = baud_div >= `SFL_BAUD_MIN;
  assign div = div_ok ? baud_div : `SFL_BAUD_MIN;
  // receiver source selection
  always_comb begin
    if (!ctrl1[`SFL_B_LOOP]) begin
      rx_in = rxd_s2;
    end else if (ctrl1[`SFL_B_SRC]) begin
      rx_in = txi_s2;
    end else begin
      rx_in = tx_line;
    end
  end
  sfl_fifo #(.WIDTH(`SFL_FIFO_W), .DEPTH(`SFL_FIFO_D)) u_txbuf (
    .clk(clk), .rst(rst),
    .in_valid(wr && hit_data), .in_ready(f_ready), .in_data(pwdata[8:0]),
    .out_valid(f_valid), .out_ready(f_pop), .out_data(f_data)
  );
  // --------------------------------------------------------------------
  // transmitter
  // --------------------------------------------------------------------
  always_comb begin
    tx_char = f_data;
    if (ctrl1[`SFL_B_PON]) begin
      if (nine) begin
        tx_char[8] = ^f_data[7:0] ^ ctrl1[`SFL_B_PODD];
      end else begin
        tx_char[7] = ^f_data[6:0] ^ ctrl1[`SFL_B_PODD];
      end
    end
    tx_frame = nine ? {1'b1, tx_char, 1'b0} : {2'b11, tx_char[7:0], 1'b0};
    load = tx_on && tx_st == sfl_tx_idle && f_valid;
    f_pop = load;
    next_tx_st = tx_st;
    next_tx_tmr = tx_tmr;
    next_tx_sh = tx_sh;
    next_tx_left = tx_left;
    next_tx_line = tx_line;
    if (!tx_on) begin
      next_tx_st = sfl_tx_idle;
      next_tx_line = 1'b1;
    end else if (load) begin
      next_tx_st = sfl_tx_shift;
      next_tx_sh = tx_frame >> 1;
      next_tx_left = nbits + 4'd1;
      next_tx_tmr = div - 16'd1;
      next_tx_line = 1'b0;
    end else if (tx_st == sfl_tx_shift) begin
      if (tx_tmr != 16'd0) begin
        next_tx_tmr = tx_tmr - 16'd1;
      end else if (tx_left == 4'd0) begin
        next_tx_st = sfl_tx_idle;
      end else begin
        next_tx_line = tx_sh[0];
        next_tx_sh = tx_sh >> 1;
        next_tx_left = tx_left - 4'd1;
        next_tx_tmr = div - 16'd1;
      end
    end
    next_txd_oe_n = !(enab[`SFL_E_TX] && (!(ctrl1[`SFL_B_LOOP]
                    && ctrl1[`SFL_B_SRC]) || tx_st == sfl_tx_shift));
  end
  // --------------------------------------------------------------------
  // receiver, idle detection and wakeup
  // --------------------------------------------------------------------
  assign rx_char = nine ? rx_sh : {1'b0, rx_sh[8:1]};
  always_comb begin
    next_rx_st = rx_st;
    next_rx_tmr = rx_tmr;
    next_rx_sh = rx_sh;
    next_rx_cnt = rx_cnt;
    next_ones = ones;
    next_armed = armed;
    done = 1'b0;
    if (!rx_on) begin
      next_rx_st = sfl_rx_idle;
      next_rx_tmr = 16'd0;
      next_ones = 4'd0;
    end else begin
      case (rx_st)
        sfl_rx_idle: begin
          if (!rx_in) begin
            next_rx_st = sfl_rx_start;
            next_rx_tmr = div >> 1;
          end else if (rx_tmr != 16'd0) begin
            next_rx_tmr = rx_tmr - 16'd1;
          end else begin
            next_rx_tmr = div - 16'd1;
            next_ones = (ones == 4'hf) ? ones : ones + 4'd1;
          end
        end
        sfl_rx_start: begin
          if (rx_tmr != 16'd0) begin
            next_rx_tmr = rx_tmr - 16'd1;
          end else begin
            next_rx_st = rx_in ? sfl_rx_idle : sfl_rx_data;
            next_rx_tmr = div - 16'd1;
            next_rx_cnt = 4'd0;
            next_ones = 4'd0;
          end
        end
        sfl_rx_data: begin
          if (rx_tmr != 16'd0) begin
            next_rx_tmr = rx_tmr - 16'd1;
          end else begin
            next_rx_sh = {rx_in, rx_sh[8:1]};
            next_rx_cnt = rx_cnt + 4'd1;
            next_rx_tmr = div - 16'd1;
            if (!ctrl1[`SFL_B_IDLE]) begin
              next_ones = rx_in ? ones + 4'd1 : 4'd0;
            end
            if (rx_cnt + 4'd1 == nbits) begin
              next_rx_st = sfl_rx_stop;
            end
          end
        end
        sfl_rx_stop: begin
          if (rx_tmr != 16'd0) begin
            next_rx_tmr = rx_tmr - 16'd1;
          end else begin
            done = 1'b1;
            next_armed = 1'b1;
            next_rx_st = sfl_rx_idle;
            next_rx_tmr = div - 16'd1;
            if (ctrl1[`SFL_B_IDLE] || !rx_in) begin
              next_ones = 4'd0;
            end else begin
              next_ones = ones + 4'd1;
            end
          end
        end
        default: next_rx_st = sfl_rx_idle;
      endcase
    end
    idle_ev = armed && next_ones >= flen && ones < flen;
    if (idle_ev) begin
      next_armed = 1'b0;
    end
  end
  // a sleeping receiver stores a character only when the wakeup bit is set and the character is address-marked
  assign keep = !enab[`SFL_E_SLEEP] ||
                (ctrl1[`SFL_B_WAKE] && rx_char[nbits-4'd1]);
  // --------------------------------------------------------------------
  // register file and apb slave
  // --------------------------------------------------------------------
  always_comb begin
    next_baud_div = baud_div;
    next_ctrl1 = ctrl1;
    next_enab = enab;
    next_rx_data = rx_data;
    next_rx_full = rx_full && !(rd && hit_data);
    next_ovr = ovr;
    next_perr = perr;
    next_ferr = ferr;
    next_idle_f = idle_f;
    if (wr && hit_baud) next_baud_div = pwdata[15:0];
    if (wr && hit_ctrl) next_ctrl1 = pwdata[7:0];
    if (wr && hit_enab) next_enab = pwdata[3:0];
    if (wr && hit_stat) begin
      next_ovr = ovr && !pwdata[3];
      next_perr = perr && !pwdata[4];
      next_ferr = ferr && !pwdata[5];
      next_idle_f = idle_f && !pwdata[6];
    end
    // hardware sets win over software clears
    if (idle_ev) begin
      next_idle_f = 1'b1;
      if (!ctrl1[`SFL_B_WAKE]) next_enab[`SFL_E_SLEEP] = 1'b0;
    end
    if (done && keep) begin
      next_enab[`SFL_E_SLEEP] = 1'b0;
      if (rx_full && !(rd && hit_data)) begin
        next_ovr = 1'b1;
      end else begin
        next_rx_data = rx_char;
        next_rx_full = 1'b1;
        if (ctrl1[`SFL_B_PON] && (^rx_char ^ ctrl1[`SFL_B_PODD])) begin
          next_perr = 1'b1;
        end
        if (!rx_in) next_ferr = 1'b1;
      end
    end
    // answer one cycle into the access phase; a full buffer stalls
    next_pready = psel && penable && !pready &&
                  !(hit_data && pwrite && !f_ready);
    next_pslverr = next_pready && !mapped;
    next_prdata = 32'h0;
    if (next_pready && !pwrite) begin
      case (1'b1)
        hit_baud: next_prdata = {16'h0, baud_div};
        hit_enab: next_prdata = {28'h0, enab};
        hit_ctrl: next_prdata = {24'h0, ctrl1};
        hit_data: next_prdata = {23'h0, rx_data};
        hit_stat: next_prdata = {24'h0, tx_st == sfl_tx_shift, idle_f,
                                 ferr, perr, ovr, rx_full, !f_ready,
                                 !f_valid};
        default: next_prdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_div <= `SFL_BAUD_RST;
      ctrl1 <= `SFL_CTRL1_RST;
      enab <= `SFL_ENAB_RST;
      rx_data <= 9'h0;
      rx_full <= 1'b0;
      ovr <= 1'b0;
      perr <= 1'b0;
      ferr <= 1'b0;
      idle_f <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      txi_s1 <= 1'b1;
      txi_s2 <= 1'b1;
      tx_st <= sfl_tx_idle;
      tx_tmr <= 16'h0;
      tx_sh <= 11'h7ff;
      tx_left <= 4'h0;
      tx_line <= 1'b1;
      txd_out <= 1'b1;
      txd_oe_n <= 1'b1;
      rx_st <= sfl_rx_idle;
      rx_tmr <= 16'h0;
      rx_sh <= 9'h0;
      rx_cnt <= 4'h0;
      ones <= 4'h0;
      armed <= 1'b0;
    end else begin
      baud_div <= next_baud_div;
      ctrl1 <= next_ctrl1;
      enab <= next_enab;
      rx_data <= next_rx_data;
      rx_full <= next_rx_full;
      ovr <= next_ovr;
      perr <= next_perr;
      ferr <= next_ferr;
      idle_f <= next_idle_f;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
      txi_s1 <= txd_in;
      txi_s2 <= txi_s1;
      tx_st <= next_tx_st;
      tx_tmr <= next_tx_tmr;
      tx_sh <= next_tx_sh;
      tx_left <= next_tx_left;
      tx_line <= next_tx_line;
      txd_out <= next_tx_line;
      txd_oe_n <= next_txd_oe_n;
      rx_st <= next_rx_st;
      rx_tmr <= next_rx_tmr;
      rx_sh <= next_rx_sh;
      rx_cnt <= next_rx_cnt;
      ones <= next_ones;
      armed <= next_armed;
    end
  end
  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  property p_loop_int;
    @(posedge clk) disable iff (rst)
    (ctrl1[7] && !ctrl1[5]) |-> (rx_in == txd_out);
  endproperty
  a_loop_int: assert property (p_loop_int)
    else $error("internal loop does not feed tx output to receiver");
  property p_single;
    @(posedge clk) disable iff (rst)
    (ctrl1[7] && ctrl1[5]) |-> (rx_in == $past(txd_in, 2));
  endproperty
  a_single: assert property (p_single)
    else $error("single-wire mode does not read the transmit pin");
  property p_normal;
    @(posedge clk) disable iff (rst)
    !ctrl1[7] |-> (rx_in == $past(rxd, 2));
  endproperty
  a_normal: assert property (p_normal)
    else $error("normal mode does not read the receive pin");
  property p_halt;
    @(posedge clk) disable iff (rst)
    (wait_mode && ctrl1[6]) |=> (tx_st == sfl_tx_idle && txd_out);
  endproperty
  a_halt: assert property (p_halt)
    else $error("serial logic still runs while halted in wait");
  property p_len;
    @(posedge clk) disable iff (rst)
    load |=> (tx_left == ($past(ctrl1[4]) ? 4'd10 : 4'd9)) && !txd_out;
  endproperty
  a_len: assert property (p_len)
    else $error("frame length does not follow character length bit");
  property p_wake;
    @(posedge clk) disable iff (rst)
    (idle_ev && !ctrl1[3] && !(wr && hit_enab)) |=> !enab[3];
  endproperty
  a_wake: assert property (p_wake)
    else $error("idle line did not wake the receiver");
  property p_ilt;
    @(posedge clk) disable iff (rst)
    (done && ctrl1[2]) |=> (ones == 4'd0);
  endproperty
  a_ilt: assert property (p_ilt)
    else $error("idle count not restarted after stop bit");
  property p_par;
    @(posedge clk) disable iff (rst)
    (load && ctrl1[1] && !ctrl1[4]) |=>
      (tx_sh[7] == (^$past(f_data[6:0]) ^ $past(ctrl1[0])));
  endproperty
  a_par: assert property (p_par)
    else $error("parity bit not placed in character msb");
  property p_alt_map_select;
    @(posedge clk) disable iff (rst)
    (psel && penable && !pready && enab[2] && aligned
     && idx == `SFL_IDX_CTRL1) |=> (pready && pslverr && prdata == 32'h0)
     ##1 $stable(ctrl1);
  endproperty
  a_alt_map_select: assert property (p_alt_map_select)
    else $error("control register visible with alt map selected");
  c_frame: cover property (@(posedge clk) disable iff (rst) done && keep);
  c_loop: cover property (@(posedge clk) disable iff (rst)
    done && ctrl1[7] && !ctrl1[5]);
  c_full: cover property (@(posedge clk) disable iff (rst) !f_ready);
  c_idle: cover property (@(posedge clk) disable iff (rst) idle_ev);
endmodule : sfl_top

// ---- core/sfl_defs.svh ----
// constants for the serial frame and loop control block
// assumes byte addressing over a 32-bit apb bus, one word per register
`ifndef SFL_DEFS_SVH
`define SFL_DEFS_SVH
// register indexes; byte address is four times the index
`define SFL_IDX_BAUD 3'h0
`define SFL_IDX_ENAB 3'h1
`define SFL_IDX_CTRL1 3'h2
`define SFL_IDX_DATA 3'h3
`define SFL_IDX_STAT 3'h4
// serial_control_one fields
`define SFL_B_LOOP 7
`define SFL_B_HALT 6
`define SFL_B_SRC 5
`define SFL_B_NINE 4
`define SFL_B_WAKE 3
`define SFL_B_IDLE 2
`define SFL_B_PON 1
`define SFL_B_PODD 0
// enable register fields
`define SFL_E_TX 0
`define SFL_E_RX 1
`define SFL_E_ALTMAP 2
`define SFL_E_SLEEP 3
// reset values
`define SFL_CTRL1_RST 8'h00
`define SFL_ENAB_RST 4'h0
`define SFL_BAUD_RST 16'h0364
`define SFL_BAUD_MIN 16'h0002
// data path buffer
`define SFL_FIFO_W 9
`define SFL_FIFO_D 32
`endif

// ---- core/sfl_pkg.sv ----
// types shared by the serial frame and loop control block
// assumes sfl_defs.svh carries all numeric constants
package sfl_pkg;
  typedef enum logic [1:0] {sfl_rx_idle, sfl_rx_start, sfl_rx_data,
                            sfl_rx_stop} sfl_rx_state_t;
  typedef enum logic {sfl_tx_idle, sfl_tx_shift} sfl_tx_state_t;
endpackage : sfl_pkg

// ---- bench/sfl_remote.sv ----
// remote serial node: sends frames on rxd or the transmit pin, and
// decodes frames seen on the transmit pin; bit time is DIV clocks
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// remote node
// ----------------------------------------------------------------------
module sfl_remote #(
  parameter int DIV = 16
) (
  input wire logic clk, // bench clock
  input wire logic pin_in, // transmit pin level
  output logic rxd_o, // drive onto the receive pin
  output logic pin_o // drive onto the transmit pin, 1 when released
);
  initial begin
    rxd_o = 1'b1;
    pin_o = 1'b1;
  end

  // start, n char bits lsb first, stop; released lines rest high
  task automatic send(input logic [9:0] v, input int n, input bit on_pin);
    logic [11:0] f;
    f = 12'hfff;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[i+1] = v[i];
    for (int i = 0; i < n + 2; i++) begin
      if (on_pin) pin_o <= f[i];
      else rxd_o <= f[i];
      repeat (DIV) @(posedge clk);
    end
  endtask : send

  // got is 0 on no start within 400 clocks or a low stop bit
  task automatic recv(output logic [9:0] v, input int n, output bit got);
    int t;
    v = 10'h000;
    got = 1'b0;
    t = 0;
    while (pin_in !== 1'b0 && t < 400) begin
      @(posedge clk);
      t++;
    end
    if (t < 400) begin
      repeat (DIV / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
        repeat (DIV) @(posedge clk);
        v[i] = pin_in;
      end
      repeat (DIV) @(posedge clk);
      got = (pin_in === 1'b1);
    end
  endtask : recv
endmodule : sfl_remote

// ---- bench/sfl_top_test.sv ----
// self-checking bench for sfl_top over apb with a remote serial node
// assumes an apb slave that answers with pready, bit time 16 clocks
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// bench top
// ----------------------------------------------------------------------
module sfl_top_test;
  typedef struct {
    logic [7:0] ctrl;
    logic [9:0] expv;
    int n;
  } sfl_row_t;
  sfl_row_t rows [5] = '{'{8'h00, 10'h0a5, 8}, '{8'h03, 10'h025, 8},
    '{8'h02, 10'h0a5, 8}, '{8'h10, 10'h1a5, 9}, '{8'h12, 10'h0a5, 9}};
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, wait_mode = 1'b0, rxd_en = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, txd_out, txd_oe_n, rxd_m, pin_m, e;
  logic [9:0] v;
  bit got;
  int errors = 0, tests_run = 0;
  wire txd_pin = !txd_oe_n ? txd_out : pin_m;
  wire rxd_w = rxd_m & rxd_en;

  always #5 clk = ~clk;

  sfl_top i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode),
    .rxd(rxd_w), .txd_in(txd_pin), .txd_out(txd_out),
    .txd_oe_n(txd_oe_n));
  sfl_remote #(.DIV(16)) i_rem (.clk(clk), .pin_in(txd_pin),
    .rxd_o(rxd_m), .pin_o(pin_m));

  task automatic chk(string nm, logic [31:0] ex, logic [31:0] gt);
    tests_run++;
    if (gt !== ex) begin
      $display("ERROR %s expected %h seen %h", nm, ex, gt);
      errors++;
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready is taken at the rising edge, before that edge updates it
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic drain();
    do begin
      apb(8'h10, 1'b0, 32'h0);
    end while (r[0] !== 1'b1 || r[7] !== 1'b0);
  endtask : drain

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (50000) @(posedge clk);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk);
    chk("txd_out in reset", 1, txd_out);
    chk("txd_oe_n in reset", 1, txd_oe_n);
    rst <= 1'b0;
    apb(8'h08, 1'b0, 32'h0);
    chk("ctrl reset", 32'h0, r);
    apb(8'h00, 1'b1, 32'd16);
    apb(8'h08, 1'b1, 32'h5a);
    apb(8'h08, 1'b0, 32'h0);
    chk("ctrl rw", 32'h5a, r);
    apb(8'h14, 1'b0, 32'h0);
    chk("unmapped err", 1, e);
    apb(8'h04, 1'b1, 32'h4);
    apb(8'h08, 1'b1, 32'h33);
    chk("alt map err", 1, e);
    apb(8'h04, 1'b1, 32'h1);
    apb(8'h08, 1'b0, 32'h0);
    chk("ctrl kept", 32'h5a, r);
    foreach (rows[i]) begin
      apb(8'h08, 1'b1, {24'h0, rows[i].ctrl});
      apb(8'h0c, 1'b1, 32'h1a5);
      i_rem.recv(v, rows[i].n, got);
      chk("tx frame", rows[i].expv, v);
      chk("tx stop", 1, got);
      repeat (20) @(posedge clk);
    end
    apb(8'h04, 1'b1, 32'h3);
    apb(8'h08, 1'b1, 32'h02);
    i_rem.send(10'h0a5, 8, 1'b0);
    apb(8'h10, 1'b0, 32'h0);
    chk("good parity", 0, r[4]);
    apb(8'h0c, 1'b0, 32'h0);
    chk("rx data", 32'h0a5, r);
    i_rem.send(10'h025, 8, 1'b0);
    apb(8'h10, 1'b0, 32'h0);
    chk("bad parity", 1, r[4]);
    apb(8'h0c, 1'b0, 32'h0);
    apb(8'h10, 1'b1, 32'h78);
    rxd_en <= 1'b0;
    apb(8'h08, 1'b1, 32'h80);
    apb(8'h0c, 1'b1, 32'h3c);
    repeat (220) @(posedge clk);
    apb(8'h0c, 1'b0, 32'h0);
    chk("internal loop", 32'h3c, r);
    apb(8'h08, 1'b1, 32'ha0);
    i_rem.send(10'h05a, 8, 1'b1);
    repeat (4) @(posedge clk);
    apb(8'h0c, 1'b0, 32'h0);
    chk("single wire", 32'h5a, r);
    rxd_en <= 1'b1;
    apb(8'h04, 1'b1, 32'hb);
    apb(8'h08, 1'b1, 32'h08);
    i_rem.send(10'h012, 8, 1'b0);
    apb(8'h10, 1'b0, 32'h0);
    chk("asleep drops", 0, r[2]);
    i_rem.send(10'h092, 8, 1'b0);
    apb(8'h0c, 1'b0, 32'h0);
    chk("address mark", 32'h92, r);
    // asleep with idle wakeup, idle counted from the stop bit
    apb(8'h04, 1'b1, 32'hb);
    apb(8'h08, 1'b1, 32'h04);
    i_rem.send(10'h034, 8, 1'b0);
    repeat (200) @(posedge clk);
    apb(8'h04, 1'b0, 32'h0);
    chk("idle wakes", 32'h3, r);
    apb(8'h10, 1'b0, 32'h0);
    chk("idle seen", 1, r[6]);
    chk("idle drops char", 0, r[2]);
    apb(8'h04, 1'b1, 32'h1);
    apb(8'h08, 1'b1, 32'h40);
    wait_mode <= 1'b1;
    apb(8'h0c, 1'b1, 32'h11);
    i_rem.recv(v, 8, got);
    chk("halted in wait", 0, got);
    apb(8'h08, 1'b1, 32'h00);
    apb(8'h0c, 1'b1, 32'h22);
    i_rem.recv(v, 8, got);
    chk("runs in wait", 1, got);
    wait_mode <= 1'b0;
    drain();
    apb(8'h04, 1'b1, 32'h0);
    for (int i = 0; i < 32; i++) apb(8'h0c, 1'b1, i);
    apb(8'h10, 1'b0, 32'h0);
    chk("buffer full", 32'h2, r[1:0]);
    apb(8'h04, 1'b1, 32'h1);
    drain();
    chk("buffer drained", 32'h1, r[1:0]);
    // reset in mid-run restores the registers and releases the pin
    apb(8'h08, 1'b1, 32'h5a);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("txd_oe_n mid reset", 1, txd_oe_n);
    chk("txd_out mid reset", 1, txd_out);
    rst <= 1'b0;
    @(posedge clk);
    chk("pready after reset", 0, pready);
    apb(8'h08, 1'b0, 32'h0);
    chk("ctrl after reset", 32'h0, r);
    apb(8'h00, 1'b0, 32'h0);
    chk("baud after reset", 32'h364, r);
    wrap_up();
  end
endmodule : sfl_top_test
